// *** inc/rmiip_map.vh ***
`ifndef RMIIP_MAP_VH
`define RMIIP_MAP_VH
// reference clock figures (bench link clock period 160 ns)
`define RMIIP_REF_FREQ_MHZ 50
`define RMIIP_SYS_FREQ_MHZ 100
// management clock half period in system cycles
`define RMIIP_MDC_HALF 8'h04
// preamble and start-of-frame bytes
`define RMIIP_PREAMBLE 8'h55
`define RMIIP_SFD 8'hD5
`define RMIIP_PREAMBLE_LEN 4'h7
// management frame length in bits: 32 preamble + 32 body
`define RMIIP_MGMT_BITS 7'h40
// bit position where the read turnaround starts (read frames release the line)
`define RMIIP_MGMT_TA_BIT 7'h2E
`endif

// *** src/rmiip_mac.v ***
`include "rmiip_map.vh"
`default_nettype none
// Summary of operation
// R1 - mac drives management clock; management data captured on its rising edges
// R2 - management data line is two-way, carrying control and status
// R3 - transmit data leaves two bits at a time on tx_dibit
// R4 - tx_frame_enable rises together with the first preamble di-bit
// R5 - tx_frame_enable stays high over all frame di-bits, falls after last; mac keeps it high when the next frame's first byte is already buffered
// R6 - enable and di-bits change only on reference clock rising edges
// R7 - phy supplies 50 MHz reference clock, 50 ppm, 35 percent phases; the bench phy model supplies a 160 ns period instead
// R8 - phy delivers receive data two bits at a time on rx_dibit
// R9 - phy raises carrier_valid whenever the medium is not idle
// R10 - phy drops carrier_valid synchronously and only on di-bit boundaries
// R11 - phy holds rx_symbol_error longer than one reference period
// R12 - error seen during a frame reports the frame as crc error
// R13 - receive pins sampled on reference clock rising edges
// R14 - first di-bit after carrier_valid rises starts preamble; lsb pair first
module rmiip_mac
(
    input wire SYS_CLK,
    input wire RST_N,
    input wire LINK_REF_CLOCK,
    input wire TX_VALID,
    output wire TX_READY,
    input wire [7:0] TX_DATA,
    input wire TX_LAST,
    output reg [1:0] TX_DIBIT,
    output reg TX_FRAME_ENABLE,
    input wire [1:0] RX_DIBIT,
    input wire CARRIER_VALID,
    input wire RX_SYMBOL_ERROR,
    output reg RX_VALID,
    output reg [7:0] RX_DATA,
    output reg RX_END,
    output reg RX_CRC_ERROR,
    input wire MGMT_START,
    input wire MGMT_READ,
    input wire [31:0] MGMT_WORD,
    output wire MGMT_BUSY,
    output reg [15:0] MGMT_RDATA,
    output reg MGMT_CLOCK_OUT,
    input wire MGMT_DATA_IN,
    output reg MGMT_DATA_OUT,
    output reg MGMT_DATA_OE
);
    localparam TX_IDLE = 3'b001;
    localparam TX_PRE = 3'b010;
    localparam TX_BODY = 3'b100;

    // ****************************************
    // pin synchronisers and reference edge
    // ****************************************
    reg [1:0] ref_sync;
    reg ref_prev;
    reg [1:0] rxd_s0, rxd_s1;
    reg crs_s0, crs_s1, err_s0, err_s1;
    reg mdi_s0, mdi_s1;
    wire ref_rise;
    // first stages are read only by second stages
    always @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ref_sync <= 2'h0;
            ref_prev <= 1'b0;
            rxd_s0 <= 2'h0;
            rxd_s1 <= 2'h0;
            crs_s0 <= 1'b0;
            crs_s1 <= 1'b0;
            err_s0 <= 1'b0;
            err_s1 <= 1'b0;
            mdi_s0 <= 1'b0;
            mdi_s1 <= 1'b0;
        end
        else
        begin
            ref_sync <= {ref_sync[0], LINK_REF_CLOCK};
            ref_prev <= ref_sync[1];
            rxd_s0 <= RX_DIBIT;
            rxd_s1 <= rxd_s0;
            crs_s0 <= CARRIER_VALID;
            crs_s1 <= crs_s0;
            err_s0 <= RX_SYMBOL_ERROR;
            err_s1 <= err_s0;
            mdi_s0 <= MGMT_DATA_IN;
            mdi_s1 <= mdi_s0;
        end
    end
    // one-cycle enable on each reference rising edge
    assign ref_rise = ref_sync[1] & ~ref_prev; // R6 R13

    // ****************************************
    // two-entry transmit buffer
    // ****************************************
    reg [8:0] buf_mem [0:1];
    reg buf_wp, buf_rp;
    reg [1:0] buf_cnt;
    wire buf_pop;
    wire buf_push;
    assign TX_READY = (buf_cnt != 2'h2);
    assign buf_push = TX_VALID & TX_READY;
    // buffer absorbs a stall by the link while the user keeps a word ready
    always @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
        end
        else
        begin
            if (buf_push)
                buf_wp <= ~buf_wp;
            if (buf_pop)
                buf_rp <= ~buf_rp;
            buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end
    always @(posedge SYS_CLK)
    begin
        if (buf_push)
            buf_mem[buf_wp] <= {TX_LAST, TX_DATA};
    end

    // ****************************************
    // transmit serialiser
    // ****************************************
    reg [2:0] tx_state;
    reg [8:0] tx_shift;
    reg [1:0] tx_pair;
    reg [3:0] tx_pre_cnt;
    wire pair_done;
    wire [7:0] pre_plain;
    wire [7:0] pre_byte;
    wire [7:0] pre_shifted;
    assign pair_done = (tx_pair == 2'h3);
    // the byte after seven preamble bytes is the start byte; pick the pair by position
    assign pre_plain = `RMIIP_PREAMBLE;
    assign pre_byte = (tx_pre_cnt == `RMIIP_PREAMBLE_LEN) ? `RMIIP_SFD : `RMIIP_PREAMBLE;
    assign pre_shifted = pre_byte >> {tx_pair, 1'b0};
    // a byte is taken from the buffer when a frame starts from idle and at a byte boundary of the body
    assign buf_pop = ref_rise & (buf_cnt != 2'h0) &
        ((tx_state == TX_IDLE) | ((tx_state == TX_BODY) & pair_done & ~tx_shift[8]));
    // pins move only on the reference enable, one di-bit per edge
    always @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            tx_state <= TX_IDLE;
            tx_shift <= 9'h000;
            tx_pair <= 2'h0;
            tx_pre_cnt <= 4'h0;
            TX_DIBIT <= 2'h0;
            TX_FRAME_ENABLE <= 1'b0;
        end
        else if (ref_rise) // R6
        begin
            case (tx_state)
                TX_IDLE:
                begin
                    TX_DIBIT <= 2'h0;
                    TX_FRAME_ENABLE <= 1'b0;
                    if (buf_cnt != 2'h0)
                    begin
                        tx_shift <= buf_mem[buf_rp];
                        tx_state <= TX_PRE;
                        tx_pre_cnt <= 4'h0;
                        tx_pair <= 2'h1;
                        TX_DIBIT <= pre_plain[1:0]; // R3
                        TX_FRAME_ENABLE <= 1'b1; // R4
                    end
                end
                TX_PRE:
                begin
                    tx_pair <= tx_pair + 2'h1;
                    TX_DIBIT <= pre_shifted[1:0]; // R3
                    if (pair_done)
                    begin
                        tx_pre_cnt <= tx_pre_cnt + 4'h1;
                        if (tx_pre_cnt == `RMIIP_PREAMBLE_LEN)
                            tx_state <= TX_BODY;
                    end
                end
                TX_BODY:
                begin
                    TX_FRAME_ENABLE <= 1'b1; // R5
                    TX_DIBIT <= tx_shift[1:0]; // R3
                    tx_shift <= {tx_shift[8], 2'h0, tx_shift[7:2]};
                    tx_pair <= tx_pair + 2'h1;
                    if (pair_done)
                    begin
                        if (tx_shift[8])
                            tx_state <= TX_IDLE;
                        else if (buf_cnt != 2'h0)
                            tx_shift <= buf_mem[buf_rp];
                        else
                            tx_shift <= {1'b1, 8'h00}; // underrun: send one zero byte, then close the frame
                    end
                end
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    // ****************************************
    // receive deserialiser
    // ****************************************
    reg rx_active, rx_in_body, rx_err_seen;
    reg [7:0] rx_shift;
    reg [1:0] rx_pair;
    // sampled once per reference rising edge; preamble dropped at the start byte
    always @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rx_active <= 1'b0;
            rx_in_body <= 1'b0;
            rx_err_seen <= 1'b0;
            rx_shift <= 8'h00;
            rx_pair <= 2'h0;
            RX_VALID <= 1'b0;
            RX_DATA <= 8'h00;
            RX_END <= 1'b0;
            RX_CRC_ERROR <= 1'b0;
        end
        else
        begin
            RX_VALID <= 1'b0;
            RX_END <= 1'b0;
            if (ref_rise) // R13
            begin
                if (crs_s1)
                begin
                    rx_active <= 1'b1;
                    if (err_s1)
                        rx_err_seen <= 1'b1; // R12
                    rx_shift <= {rxd_s1, rx_shift[7:2]}; // R14
                    rx_pair <= rx_active ? rx_pair + 2'h1 : 2'h1; // R14
                    if (!rx_in_body && {rxd_s1, rx_shift[7:2]} == `RMIIP_SFD)
                    begin
                        rx_in_body <= 1'b1;
                        rx_pair <= 2'h0;
                    end
                    else if (rx_in_body && rx_pair == 2'h3)
                    begin
                        RX_VALID <= 1'b1;
                        RX_DATA <= {rxd_s1, rx_shift[7:2]};
                    end
                end
                else if (rx_active)
                begin
                    // carrier falls on a di-bit boundary, so no partial pair is lost
                    rx_active <= 1'b0;
                    rx_in_body <= 1'b0;
                    rx_err_seen <= 1'b0;
                    rx_shift <= 8'h00; // stale bits could fake a start byte next frame
                    RX_END <= 1'b1;
                    RX_CRC_ERROR <= rx_err_seen | err_s1; // R12
                end
            end
        end
    end

    // ****************************************
    // management clock and data line
    // ****************************************
    reg [7:0] md_div;
    reg [6:0] md_bit;
    reg md_run, md_read;
    reg [63:0] md_shift;
    assign MGMT_BUSY = md_run;
    // data changes on the falling edge so the phy captures on the rising one
    always @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            md_div <= 8'h00;
            md_bit <= 7'h00;
            md_run <= 1'b0;
            md_read <= 1'b0;
            md_shift <= 64'h0000000000000000;
            MGMT_RDATA <= 16'h0000;
            MGMT_CLOCK_OUT <= 1'b0;
            MGMT_DATA_OUT <= 1'b0;
            MGMT_DATA_OE <= 1'b0;
        end
        else if (!md_run)
        begin
            MGMT_CLOCK_OUT <= 1'b0;
            MGMT_DATA_OE <= 1'b0;
            if (MGMT_START)
            begin
                md_run <= 1'b1;
                md_read <= MGMT_READ;
                // the first preamble bit is put on the line now, so the rest shifts out
                md_shift <= {31'h7FFFFFFF, MGMT_WORD, 1'b0};
                md_bit <= 7'h00;
                md_div <= 8'h00;
                MGMT_DATA_OE <= 1'b1; // R2
                MGMT_DATA_OUT <= 1'b1;
            end
        end
        else if (md_div == `RMIIP_MDC_HALF - 8'h01)
        begin
            md_div <= 8'h00;
            MGMT_CLOCK_OUT <= ~MGMT_CLOCK_OUT; // R1
            if (!MGMT_CLOCK_OUT)
            begin
                // rising edge: read frames capture the phy's bit here
                if (md_read && md_bit > `RMIIP_MGMT_TA_BIT + 7'h01)
                    MGMT_RDATA <= {MGMT_RDATA[14:0], mdi_s1}; // R1
                md_bit <= md_bit + 7'h01;
            end
            else if (md_bit == `RMIIP_MGMT_BITS)
            begin
                md_run <= 1'b0;
                MGMT_DATA_OE <= 1'b0;
            end
            else
            begin
                MGMT_DATA_OUT <= md_shift[63];
                md_shift <= {md_shift[62:0], 1'b0};
                MGMT_DATA_OE <= ~(md_read && md_bit >= `RMIIP_MGMT_TA_BIT); // R2
            end
        end
        else
            md_div <= md_div + 8'h01;
    end
endmodule // rmiip_mac
`default_nettype wire

// *** tb/rmiip_mac_checker.sv ***
`default_nettype none
// ***
// port checker for the rmii mac
// ***
module rmiip_mac_checker
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [1:0] TX_DIBIT,
    input wire logic TX_FRAME_ENABLE,
    input wire logic CARRIER_VALID,
    input wire logic RX_SYMBOL_ERROR,
    input wire logic RX_VALID,
    input wire logic RX_END,
    input wire logic RX_CRC_ERROR,
    input wire logic MGMT_CLOCK_OUT,
    input wire logic MGMT_DATA_OUT,
    input wire logic MGMT_DATA_OE
);
    timeunit 1ns / 1ps;
    logic err_seen;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // remembers a symbol error inside a frame until that frame is reported
    always @(posedge SYS_CLK or negedge RST_N)
        if (!RST_N)
            err_seen <= 1'b0;
        else
            err_seen <= !RX_END && (err_seen || (RX_SYMBOL_ERROR && CARRIER_VALID));
    chk_first_dibit: assert property ($rose(TX_FRAME_ENABLE) |-> TX_DIBIT == 2'h1)
        else $error("bad first di-bit");
    chk_enable_held: assert property ($rose(TX_FRAME_ENABLE) |-> TX_FRAME_ENABLE [*8])
        else $error("enable dropped early");
    chk_dibit_steady: assert property ($changed(TX_DIBIT) && TX_FRAME_ENABLE |=> $stable(TX_DIBIT) [*6])
        else $error("di-bit changed inside a period");
    chk_mdc_half: assert property ($rose(MGMT_CLOCK_OUT) |-> MGMT_CLOCK_OUT [*4] ##1 !MGMT_CLOCK_OUT)
        else $error("bad management half period");
    chk_mdio_setup: assert property ($rose(MGMT_CLOCK_OUT) && MGMT_DATA_OE |-> $stable(MGMT_DATA_OUT))
        else $error("management data moved at rise");
    chk_rx_pulse: assert property (RX_VALID |=> !RX_VALID)
        else $error("byte strobe too long");
    chk_crc_report: assert property (RX_END |-> RX_CRC_ERROR == err_seen)
        else $error("bad frame error report");
    chk_rx_quiet: assert property (!CARRIER_VALID [*8] |=> !RX_VALID)
        else $error("byte without carrier");
endmodule // rmiip_mac_checker
bind rmiip_mac rmiip_mac_checker rmiip_mac_checker_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .TX_DIBIT(TX_DIBIT), .TX_FRAME_ENABLE(TX_FRAME_ENABLE), .CARRIER_VALID(CARRIER_VALID),
    .RX_SYMBOL_ERROR(RX_SYMBOL_ERROR), .RX_VALID(RX_VALID), .RX_END(RX_END),
    .RX_CRC_ERROR(RX_CRC_ERROR), .MGMT_CLOCK_OUT(MGMT_CLOCK_OUT),
    .MGMT_DATA_OUT(MGMT_DATA_OUT), .MGMT_DATA_OE(MGMT_DATA_OE));
`default_nettype wire

// *** tb/rmiip_phy_model.sv ***
`include "rmiip_map.vh"
`default_nettype none
// ***
// link partner model
// ***
module rmiip_phy_model
(
    output logic rclk,
    output logic [1:0] rxd,
    output logic crs,
    output logic rer,
    input wire logic [1:0] txd,
    input wire logic txe,
    input wire logic mdc,
    input wire logic mdo,
    input wire logic moe,
    output wire logic mdi
);
    timeunit 1ns / 1ps;
    logic [1:0] txq[$];
    logic [63:0] sh;
    logic [15:0] rd_word;
    logic md_q;
    int cnt;
    // released line idles high through the pull-up
    assign mdi = moe ? mdo : md_q;
    // free-running reference, 160 ns here so the mac's sampler keeps up
    initial
    begin
        {rclk, rxd, crs, rer, cnt} = 0;
        md_q = 1'b1;
        forever #80 rclk = ~rclk;
    end
    // transmitted di-bits as seen at reference rises
    always @(posedge rclk)
        if (txe)
            txq.push_back(txd);
    // management bits taken on clock rises, read data moved while low
    always @(posedge mdc)
        {sh, cnt} <= {sh[62:0], mdi, cnt + 1};
    always @(negedge mdc)
        md_q <= cnt < 48 || cnt > 63 || rd_word[(63 - cnt) & 15];
    task arm(input logic [15:0] w);
        rd_word = w;
        cnt = 0;
    endtask
    // preamble, start byte, body; the error marks one whole body byte
    task rx_frame(input logic [7:0] b[$], input int err_at);
        logic [7:0] v;
        for (int i = 0; i < b.size() + 8; i++)
        begin
            v = i < 7 ? `RMIIP_PREAMBLE : i == 7 ? `RMIIP_SFD : b[i - 8];
            repeat (4)
            begin
                @(negedge rclk);
                {crs, rxd, rer} <= {1'b1, v[1:0], i - 8 == err_at};
                v = v >> 2;
            end
        end
        @(negedge rclk);
        {crs, rxd, rer} <= {1'b0, ~rxd, 1'b0};
    endtask
endmodule // rmiip_phy_model
`default_nettype wire

// *** tb/rmiip_mac_test.sv ***
`include "rmiip_map.vh"
`default_nettype none
// ***
// frames both ways, then management write and read
// ***
module rmiip_mac_test;
    timeunit 1ns / 1ps;
    logic clk, rst_n, tv, tl, ms, mr, end_seen, crc_seen;
    logic [7:0] td;
    logic [31:0] mw;
    logic [7:0] bq[$], rxq[$];
    wire rclk, trdy, txe, crs, rer, rv, rend, crc, busy, mdc, mdi, mdo, moe;
    wire [1:0] txd, rxd;
    wire [7:0] rdat;
    wire [15:0] mrd;
    int seed = 61, fail_count, checked, refused;
    rmiip_mac rmiip_mac_i (.SYS_CLK(clk), .RST_N(rst_n), .LINK_REF_CLOCK(rclk),
        .TX_VALID(tv), .TX_READY(trdy), .TX_DATA(td), .TX_LAST(tl), .TX_DIBIT(txd),
        .TX_FRAME_ENABLE(txe), .RX_DIBIT(rxd), .CARRIER_VALID(crs), .RX_SYMBOL_ERROR(rer),
        .RX_VALID(rv), .RX_DATA(rdat), .RX_END(rend), .RX_CRC_ERROR(crc), .MGMT_START(ms),
        .MGMT_READ(mr), .MGMT_WORD(mw), .MGMT_BUSY(busy), .MGMT_RDATA(mrd),
        .MGMT_CLOCK_OUT(mdc), .MGMT_DATA_IN(mdi), .MGMT_DATA_OUT(mdo), .MGMT_DATA_OE(moe));
    rmiip_phy_model phy_i (.rclk(rclk), .rxd(rxd), .crs(crs), .rer(rer), .txd(txd),
        .txe(txe), .mdc(mdc), .mdo(mdo), .moe(moe), .mdi(mdi));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // collects delivered bytes and the end-of-frame report
    always @(posedge clk)
    begin
        if (rv)
            rxq.push_back(rdat);
        if (rend)
            {end_seen, crc_seen} <= {1'b1, crc};
    end
    task chk(input string what, input logic [63:0] exp, got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    function logic [1:0] exp_dibit(input int k);
        logic [7:0] v;
        v = k < 28 ? `RMIIP_PREAMBLE : k < 32 ? `RMIIP_SFD : bq[k / 4 - 8];
        return 2'(v >> 2 * (k % 4));
    endfunction
    // holds each byte while the two-entry buffer refuses it
    task send_tx;
        foreach (bq[j])
        begin
            @(negedge clk);
            {tv, td, tl} = {1'b1, bq[j], j == bq.size() - 1};
            while (!trdy)
            begin
                refused++;
                @(negedge clk);
            end
        end
        @(negedge clk);
        {tv, tl} = 2'h0;
    endtask
    task frame_test(input int i);
        int n;
        // four or more bytes make sure the buffer refuses at least once
        n = i == 0 ? 1 : 4 + $unsigned($random(seed)) % 3;
        bq = {};
        rxq = {};
        end_seen = 1'b0;
        repeat (n) bq.push_back(8'($random(seed)));
        fork
            send_tx();
            phy_i.rx_frame(bq, i == 2 ? 0 : 99);
        join
        for (int k = 0; k < 3000 && !(end_seen && !txe && phy_i.txq.size() >= 32 + 4 * n); k++)
            @(negedge clk);
        chk("tx count", 32 + 4 * n, phy_i.txq.size());
        for (int k = 0; k < 32 + 4 * n; k++)
            chk("tx di-bit", exp_dibit(k), phy_i.txq[k]);
        chk("rx count", n, rxq.size());
        foreach (bq[k])
            chk("rx byte", bq[k], rxq[k]);
        chk("rx end", 1, end_seen);
        chk("crc error", i == 2, crc_seen);
        chk("tx drained", 1, trdy);
        phy_i.txq = {};
        $display("frame test %0d done", i);
    endtask
    task mgmt_test(input logic rd);
        logic [31:0] w;
        logic [15:0] r;
        w = $random(seed);
        r = $random(seed);
        phy_i.arm(r);
        @(negedge clk);
        {mr, mw, ms} = {rd, w, 1'b1};
        @(negedge clk);
        ms = 0;
        for (int k = 0; k < 1000 && busy; k++)
            @(negedge clk);
        chk("mdc count", 64, phy_i.cnt);
        chk("mgmt frame", rd ? {32'hFFFFFFFF, w[31:18], 2'h3, r} : {32'hFFFFFFFF, w}, phy_i.sh);
        if (rd)
            chk("read data", r, mrd);
        $display("mgmt test %0d done", rd);
    endtask
    initial
    begin
        {rst_n, tv, tl, td, ms, mr, mw} = 0;
        repeat (20) @(negedge clk);
        rst_n = 1;
        for (int i = 0; i < 3; i++)
            frame_test(i);
        mgmt_test(0);
        mgmt_test(1);
        chk("buffer refusals", 1, refused > 0);
        finish_test();
    end
    // tests need about 40 us; five times that means a hang
    initial
    begin
        #200000;
        fail_count++;
        finish_test();
    end
endmodule // rmiip_mac_test
`default_nettype wire
